// [hdl/dpll_lock_map.svh]
// Register offsets, reset values and timing constants of the lock monitor
`ifndef DPLL_LOCK_MAP_SVH
`define DPLL_LOCK_MAP_SVH
`define OFS_LC2     8'h00
`define OFS_ABW     8'h04
`define OFS_LBW     8'h08
`define OFS_PL1     8'h0C
`define OFS_PL2     8'h10
`define OFS_FL1     8'h14
`define OFS_FL2     8'h18
`define OFS_FL3     8'h1C
`define OFS_TC1     8'h20
`define OFS_MC9     8'h24
`define OFS_REFC    8'h28
`define OFS_OPST    8'h2C
`define OFS_MS2     8'h30
`define OFS_FR1     8'h34
`define OFS_FR2     8'h38
`define OFS_FR3     8'h3C
`define OFS_PR1     8'h40
`define OFS_PR2     8'h44
`define RST_DAMPING_SELECT    3'h3
`define RST_EL_EN   1'h1
`define RST_EL_GAIN 3'h2
`define RST_ABW     3'h6
`define RST_LBW     3'h2
`define RST_FINE    8'h20
`define RST_COARSE  13'h000A
`define COARSE_MIN  13'h000A
`define BW_MAX      3'h6
`define PH_SHIFT    4
`define CLK_HZ      125000000
`define LOCK_HOLD_S 2
`endif

// [hdl/dpll_lock_pkg.sv]
// Types shared by the lock monitor
package dpll_lock_pkg;
	typedef enum logic {ST_LOSS, ST_LOCKED} lock_state_t;
endpackage

// [hdl/dpll_phase_detect_lock_monitor.sv]
// Phase detectors, damping selection, loss-of-lock detection and readout of the main loop
// Notes on behaviour
// - Damping code 1..5 maps to 1.2..20, capped at 5 for 18Hz, 10 for 35Hz.
// - Detectors work for reference clocks up to 77.76MHz; here the 125MHz edge sampling limits them to 31.25MHz.
// - Multicycle detector keeps phase differences up to 8191 unit intervals.
// - References of 8kHz or below always use the plain phase/frequency detectors.
// - Two capture modes: full 360 degree locking and nearest-edge 180 degree locking.
// - Nearest-edge locking starts by itself when multicycle is off and lock is reached.
// - Force-full-capture bit inhibits nearest-edge locking.
// - Early/late detector enable and gain live in loop control two, safe defaults.
// - Multicycle runs only when enabled; range 10 to 8191 from coarse field.
// - Multicycle is switched off for 8k/4k/2k direct locking or eight-kHz lock mode.
// - Loop-use bit feeds multicycle into the loop; tracking continues regardless.
// - Divided reference realigns to feedback on new reference and after signal loss.
// - Fine lock detector compares phase to fine field while enabled.
// - Coarse detector counts cycle slips against the shared coarse field.
// - Hard frequency limit reached while enabled declares loss-of-lock.
// - Soft frequency limit sets a status bit, never loss-of-lock.
// - Inactivity detector declares loss-of-lock after missing reference cycles.
// - Loss-of-lock moves state at once, sets state-change bit, may request interrupt.
// - Frequency readout over three registers returns the integral path value.
// - Phase readout over two registers returns the filtered detector difference.
// - Bandwidth is one of seven positions from 18Hz to 400Hz.
// - From loss-of-lock, lock held over two seconds returns to locked.
// - Auto bandwidth uses acquisition setting until locked, else locked setting.
//
// Chosen here: the placing of the registers and register access over APB.
`include "dpll_lock_map.svh"
module dpll_phase_detect_lock_monitor #(
	parameter int LOCK_HOLD = `LOCK_HOLD_S * `CLK_HZ
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Reference and feedback clocks, reference selection, integral path
	input  wire logic        ref_clk_in,
	input  wire logic        fb_clk_in,
	input  wire logic        ref_sel,
	input  wire logic [23:0] integral_freq,
	// To the loop and its state machine
	output logic             lol,
	output logic             state_locked,
	output logic             nearest_edge,
	output logic             mc_active,
	output logic             mc_in_loop,
	output logic             el_enable,
	output logic [2:0]       el_gain,
	output logic [2:0]       active_bw,
	output logic [2:0]       damping_code,
	output logic             realign,
	output logic             irq
);

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0]  lc2_q;
	logic [2:0]  abw_q, lbw_q;
	logic        fine_en_q, inact_en_q, mc_en_q, use_q, coarse_en_q;
	logic [7:0]  fine_rng_q;
	logic [12:0] coarse_q;
	logic [15:0] fl1_q, soft_q;
	logic [7:0]  fl2_q;
	logic        hard_en_q, full_q, auto_q, k8_q, low_rate_q, div_q, irq_en_q, chg_q;
	logic [23:0] frd_q;
	logic [15:0] prd_q;
	logic        wr, rd_setup;
	logic [31:0] rd_d;
	logic        mapped;

	assign wr       = psel & penable & pready & pwrite;
	assign rd_setup = psel & ~penable;

	// Software-written configuration, early/late defaults fit every mode
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lc2_q      <= {`RST_EL_GAIN, `RST_EL_EN, 1'h0, `RST_DAMPING_SELECT};
			abw_q      <= `RST_ABW;
			lbw_q      <= `RST_LBW;
			{fine_en_q, inact_en_q, mc_en_q, use_q, coarse_en_q} <= 5'h00;
			fine_rng_q <= `RST_FINE;
			coarse_q   <= `RST_COARSE;
			fl1_q      <= 16'hFFFF;
			fl2_q      <= 8'h7F;
			soft_q     <= 16'hFFFF;
			{hard_en_q, full_q, auto_q, k8_q, low_rate_q, div_q, irq_en_q} <= 7'h00;
		end
		else if (wr)
		begin
			case (paddr)
				`OFS_LC2:  lc2_q <= pwdata[7:0];
				`OFS_ABW:  abw_q <= pwdata[2:0];
				`OFS_LBW:  lbw_q <= pwdata[2:0];
				`OFS_PL1:  {fine_rng_q, inact_en_q, fine_en_q} <= {pwdata[15:8], pwdata[1:0]};
				`OFS_PL2:  {coarse_q, coarse_en_q, use_q, mc_en_q} <= {pwdata[28:16], pwdata[2:0]};
				`OFS_FL1:  fl1_q <= pwdata[15:0];
				`OFS_FL2:  fl2_q <= pwdata[7:0];
				`OFS_FL3:  {soft_q, hard_en_q} <= {pwdata[23:8], pwdata[0]};
				`OFS_TC1:  full_q <= pwdata[0];
				`OFS_MC9:  {k8_q, auto_q} <= pwdata[1:0];
				`OFS_REFC: {div_q, low_rate_q} <= pwdata[1:0];
				`OFS_MS2:  irq_en_q <= pwdata[8];
				default:   ;
			endcase
		end
	end

	// ****************************************
	// Reference and feedback edges
	// ****************************************
	logic [2:0]  ref_s_q, fb_s_q;
	logic        ref_lvl_q, fb_lvl_q, ref_rise, fb_rise;
	logic [15:0] since_q, period_q;

	// Three-stage pins, an edge counts once stages two and three agree
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ref_s_q   <= 3'h0;
			fb_s_q    <= 3'h0;
			ref_lvl_q <= 1'b0;
			fb_lvl_q  <= 1'b0;
			ref_rise  <= 1'b0;
			fb_rise   <= 1'b0;
		end
		else
		begin
			ref_s_q  <= {ref_s_q[1:0], ref_clk_in};
			fb_s_q   <= {fb_s_q[1:0], fb_clk_in};
			ref_rise <= (ref_s_q[1] == ref_s_q[2]) & ref_s_q[1] & ~ref_lvl_q;
			fb_rise  <= (fb_s_q[1] == fb_s_q[2]) & fb_s_q[1] & ~fb_lvl_q;
			if (ref_s_q[1] == ref_s_q[2])
				ref_lvl_q <= ref_s_q[1];
			if (fb_s_q[1] == fb_s_q[2])
				fb_lvl_q <= fb_s_q[1];
		end
	end

	// Reference period in clock cycles; resolution limits usable rate to a quarter of the 125MHz pclk, 31.25MHz
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			since_q  <= 16'h0000;
			period_q <= 16'h0000;
		end
		else if (ref_rise)
		begin
			period_q <= since_q;
			since_q  <= 16'h0000;
		end
		else if (since_q != 16'hFFFF)
			since_q <= since_q + 16'h0001;
	end

	// ****************************************
	// Detectors
	// ****************************************
	logic signed [16:0] ph_d, ph_q, ph_abs;
	logic signed [13:0] slip_q, slip_abs, rng_s;
	logic [12:0] rng;
	logic [23:0] fabs;
	logic        miss, lost_q, sel_q, track, mc_act_d;
	logic        fine_hit, coarse_hit, hard_hit, inact_hit, lol_d;
	logic        soft_q_flag;

	// Nearest-edge folds the phase into half a period, else full-cycle capture
	always_comb
	begin
		ph_d = {1'b0, since_q};
		if (nearest_edge && since_q > (period_q >> 1))
			ph_d = {1'b0, since_q} - {1'b0, period_q};
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ph_q <= 17'sh00000;
		else if (fb_rise)
			ph_q <= ph_d;
	end

	// Slip range clamped to its lower bound, whole field reused by coarse detector
	assign rng      = (coarse_q < `COARSE_MIN) ? `COARSE_MIN : coarse_q;
	assign rng_s    = {1'b0, rng};
	assign mc_act_d = mc_en_q & ~low_rate_q & ~k8_q;
	assign track    = mc_act_d | coarse_en_q;

	// Multicycle slip counter, saturating at the programmed range
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			slip_q <= 14'sh0000;
		else if (!track || realign)
			slip_q <= 14'sh0000;
		else if (ref_rise && !fb_rise && slip_q < rng_s)
			slip_q <= slip_q + 14'sh0001;
		else if (fb_rise && !ref_rise && slip_q > -rng_s)
			slip_q <= slip_q - 14'sh0001;
	end

	assign ph_abs   = ph_q[16] ? -ph_q : ph_q;
	assign slip_abs = slip_q[13] ? -slip_q : slip_q;
	assign fabs     = integral_freq[23] ? (24'h000000 - integral_freq) : integral_freq;
	assign miss     = (period_q != 16'h0000) && ({1'b0, since_q} > {period_q, 1'b0});

	assign fine_hit   = fine_en_q & (ph_abs > $signed({9'h000, fine_rng_q}));
	assign coarse_hit = coarse_en_q & (slip_abs >= rng_s);
	assign hard_hit   = hard_en_q & (fabs >= {fl2_q, fl1_q});
	assign inact_hit  = inact_en_q & miss;
	assign lol_d      = fine_hit | coarse_hit | hard_hit | inact_hit;

	// ****************************************
	// Lock state and loop controls
	// ****************************************
	dpll_lock_pkg::lock_state_t state_q, state_d;
	logic [27:0] hold_q;

	function automatic logic [2:0] bw_clamp(input logic [2:0] bw);
		bw_clamp = (bw > `BW_MAX) ? `BW_MAX : bw;
	endfunction

	// Index 0 is 18Hz, 1 is 35Hz, 2 to 6 span 70Hz to 400Hz
	function automatic logic [2:0] damping_select_map(input logic [2:0] d, input logic [2:0] bw);
		logic [2:0] c;
		c = (d == 3'h0 || d > 3'h5) ? `RST_DAMPING_SELECT : d;
		if (bw == 3'h0 && c > 3'h3)
			c = 3'h3;
		else if (bw == 3'h1 && c > 3'h4)
			c = 3'h4;
		damping_select_map = c;
	endfunction

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			dpll_lock_pkg::ST_LOCKED: if (lol_d) state_d = dpll_lock_pkg::ST_LOSS;
			dpll_lock_pkg::ST_LOSS:   if (hold_q == 28'(LOCK_HOLD)) state_d = dpll_lock_pkg::ST_LOCKED;
			default:                  state_d = dpll_lock_pkg::ST_LOSS;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q <= dpll_lock_pkg::ST_LOSS;
			hold_q  <= 28'h0000000;
		end
		else
		begin
			state_q <= state_d;
			if (lol_d || state_q == dpll_lock_pkg::ST_LOCKED)
				hold_q <= 28'h0000000;
			else if (hold_q != 28'(LOCK_HOLD))
				hold_q <= hold_q + 28'h0000001;
		end
	end

	// State-change flag: a new change beats a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			chg_q <= 1'b0;
			irq   <= 1'b0;
		end
		else
		begin
			if (state_d != state_q)
				chg_q <= 1'b1;
			else if (wr && paddr == `OFS_MS2 && pwdata[0])
				chg_q <= 1'b0;
			irq <= irq_en_q & chg_q;
		end
	end

	// Loop controls derived from the next state so they move with it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			lol          <= 1'b0;
			nearest_edge <= 1'b0;
			mc_active    <= 1'b0;
			mc_in_loop   <= 1'b0;
			active_bw    <= `RST_LBW;
			damping_code <= `RST_DAMPING_SELECT;
			soft_q_flag  <= 1'b0;
			realign      <= 1'b0;
			lost_q       <= 1'b0;
			sel_q        <= 1'b0;
		end
		else
		begin
			lol          <= lol_d;
			nearest_edge <= ~mc_act_d & ~full_q & ~low_rate_q
				& (state_d == dpll_lock_pkg::ST_LOCKED);
			mc_active    <= mc_act_d;
			mc_in_loop   <= mc_act_d & use_q;
			active_bw    <= (auto_q && state_d != dpll_lock_pkg::ST_LOCKED) ?
				bw_clamp(abw_q) : bw_clamp(lbw_q);
			damping_code <= damping_select_map(lc2_q[2:0], (auto_q && state_d != dpll_lock_pkg::ST_LOCKED) ?
				bw_clamp(abw_q) : bw_clamp(lbw_q));
			soft_q_flag  <= fabs[23:8] >= soft_q;
			lost_q       <= miss;
			sel_q        <= ref_sel;
			realign      <= div_q & ((ref_sel != sel_q) | (lost_q & ~miss));
		end
	end

	assign state_locked = (state_q == dpll_lock_pkg::ST_LOCKED);
	assign el_enable    = lc2_q[4];
	assign el_gain      = lc2_q[7:5];

	// ****************************************
	// Readout and APB answer
	// ****************************************
	logic signed [16:0] filt_q;
	logic signed [17:0] fdiff;

	// First-order average; corner near 100Hz only at the nominal reference rate
	assign fdiff = $signed({ph_q[16], ph_q}) - $signed({filt_q[16], filt_q});
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			filt_q <= 17'sh00000;
		else if (fb_rise)
			filt_q <= filt_q + 17'(fdiff >>> `PH_SHIFT);
	end

	// Reading the low word freezes the rest so wide values do not tear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			frd_q <= 24'h000000;
			prd_q <= 16'h0000;
		end
		else if (rd_setup && !pwrite)
		begin
			if (paddr == `OFS_FR1)
				frd_q <= integral_freq;
			if (paddr == `OFS_PR1)
				prd_q <= filt_q[15:0];
		end
	end

	always_comb
	begin
		rd_d   = 32'h00000000;
		mapped = 1'b1;
		case (paddr)
			`OFS_LC2:  rd_d = {24'h000000, lc2_q};
			`OFS_ABW:  rd_d = {29'h00000000, abw_q};
			`OFS_LBW:  rd_d = {29'h00000000, lbw_q};
			`OFS_PL1:  rd_d = {16'h0000, fine_rng_q, 6'h00, inact_en_q, fine_en_q};
			`OFS_PL2:  rd_d = {3'h0, coarse_q, 13'h0000, coarse_en_q, use_q, mc_en_q};
			`OFS_FL1:  rd_d = {16'h0000, fl1_q};
			`OFS_FL2:  rd_d = {24'h000000, fl2_q};
			`OFS_FL3:  rd_d = {8'h00, soft_q, 7'h00, hard_en_q};
			`OFS_TC1:  rd_d = {31'h00000000, full_q};
			`OFS_MC9:  rd_d = {30'h00000000, k8_q, auto_q};
			`OFS_REFC: rd_d = {30'h00000000, div_q, low_rate_q};
			`OFS_OPST: rd_d = {27'h0000000, lol, mc_active, nearest_edge, soft_q_flag, state_locked};
			`OFS_MS2:  rd_d = {23'h000000, irq_en_q, 7'h00, chg_q};
			`OFS_FR1:  rd_d = {24'h000000, integral_freq[7:0]};
			`OFS_FR2:  rd_d = {24'h000000, frd_q[15:8]};
			`OFS_FR3:  rd_d = {24'h000000, frd_q[23:16]};
			`OFS_PR1:  rd_d = {24'h000000, filt_q[7:0]};
			`OFS_PR2:  rd_d = {24'h000000, prd_q[15:8]};
			default:   mapped = 1'b0;
		endcase
	end

	// Zero-wait slave: answer prepared in setup, ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else
		begin
			pready  <= rd_setup;
			pslverr <= rd_setup & ~mapped;
			if (rd_setup)
				prdata <= pwrite ? 32'h00000000 : rd_d;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	lol_follow_a: assert property (##1 lol == $past((fine_en_q && ph_abs > $signed({9'h000, fine_rng_q}))
		|| (coarse_en_q && slip_abs >= rng_s) || (hard_en_q && fabs >= {fl2_q, fl1_q}) || (inact_en_q && miss)))
		else $error("lol does not follow the gated detectors");
	loss_entry_a: assert property (state_q == dpll_lock_pkg::ST_LOCKED && lol_d
		|=> state_q == dpll_lock_pkg::ST_LOSS && chg_q)
		else $error("loss-of-lock did not move state and flag change");
	relock_a: assert property ($rose(state_locked) |-> $past(hold_q) == 28'(LOCK_HOLD))
		else $error("relocked before the hold time");
	near_edge_a: assert property (nearest_edge |-> !mc_active && state_locked)
		else $error("nearest edge while multicycle runs or unlocked");
	full_cap_a: assert property (full_q |=> !nearest_edge)
		else $error("nearest edge despite forced full capture");
	mc_off_a: assert property ((low_rate_q || k8_q) |=> !mc_active)
		else $error("multicycle runs on a low-rate reference");
	mc_loop_a: assert property (mc_in_loop |-> mc_active && $past(use_q))
		else $error("multicycle in loop while not active or not selected");
	bw_fixed_a: assert property (!auto_q |=> active_bw == bw_clamp($past(lbw_q)))
		else $error("bandwidth not the locked setting");
	soft_flag_a: assert property (fabs[23:8] >= soft_q |=> soft_q_flag)
		else $error("soft limit flag missing");

endmodule // dpll_phase_detect_lock_monitor

// [tb/ref_clock_source.sv]
// Reference and feedback clock source standing in for the timing card
module ref_clock_source #(
	parameter int HALF = 32
) (
	// Control
	input  wire logic       run,
	input  wire logic       fb_stop,
	input  wire logic [4:0] fb_lag,
	// Clocks
	output logic            ref_clk,
	output logic            fb_clk
);
	timeunit 1ns;
	timeprecision 1ns;

	// Parks low while stopped so no stray edge reaches the detectors
	initial
	begin
		ref_clk = 1'b0;
		forever
		begin
			#HALF;
			ref_clk = run ? ~ref_clk : 1'b0;
		end
	end

	// Feedback trails the reference by fb_lag ns; stopping it lets whole cycles slip
	always @(ref_clk)
		fb_clk <= #(fb_lag) (ref_clk & ~fb_stop);
endmodule // ref_clock_source

// [tb/dpll_phase_detect_lock_monitor_test.sv]
// Self-checking bench of the phase-detect lock monitor
`include "dpll_lock_map.svh"
module dpll_phase_detect_lock_monitor_test;
	timeunit 1ns;
	timeprecision 1ns;
	// ****************
	// Setup
	// ****************
	localparam int LH = 50;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ref_clk;
	logic        fb_clk;
	logic        ref_sel;
	logic [23:0] integral_freq;
	logic        lol;
	logic        state_locked;
	logic        nearest_edge;
	logic        mc_active;
	logic        mc_in_loop;
	logic        el_enable;
	logic [2:0]  el_gain;
	logic [2:0]  active_bw;
	logic [2:0]  damping_code;
	logic        realign;
	logic        irq;
	logic        run;
	logic        fb_stop;
	logic [4:0]  fb_lag;
	logic [31:0] rd;
	logic        er;
	int          n_errors;
	int          check_count;
	int          cyc;
	int          i;

	dpll_phase_detect_lock_monitor #(.LOCK_HOLD(LH)) i_dpll_phase_detect_lock_monitor (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ref_clk_in(ref_clk), .fb_clk_in(fb_clk), .ref_sel(ref_sel), .integral_freq(integral_freq),
		.lol(lol), .state_locked(state_locked), .nearest_edge(nearest_edge), .mc_active(mc_active),
		.mc_in_loop(mc_in_loop), .el_enable(el_enable), .el_gain(el_gain), .active_bw(active_bw),
		.damping_code(damping_code), .realign(realign), .irq(irq));

	ref_clock_source i_ref_clock_source (.run(run), .fb_stop(fb_stop), .fb_lag(fb_lag), .ref_clk(ref_clk),
		.fb_clk(fb_clk));

	// 125 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever
			#4 pclk = ~pclk;
	end

	// Cut a hang short well past the expected run length
	always @(posedge pclk)
	begin
		cyc++;
		if (cyc == 10000)
		begin
			n_errors++;
			test_done;
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ****************
	// Scenarios
	// ****************
	task automatic t_reset;
		chk(32'(state_locked), 32'h0);
		chk(32'(damping_code), 32'h3);
		chk({28'h0, el_gain, el_enable}, 32'h5);
		apb(1'b0, `OFS_LC2, 32'h0);
		chk(rd, 32'h53);
		apb(1'b0, `OFS_PL2, 32'h0);
		chk(rd, 32'h000A0000);
		apb(1'b0, 8'h48, 32'h0);
		chk({31'h0, er}, 32'h1);
		apb(1'b1, `OFS_OPST, 32'hFF);
		apb(1'b0, `OFS_OPST, 32'h0);
		chk(rd, 32'h0);
		for (i = 0; i < 200 && state_locked !== 1'b1; i++)
			@(posedge pclk);
		chk(32'(state_locked), 32'h1);
		$display("test reset finished");
	endtask

	task automatic t_damping_select;
		int bw;
		int d;
		int e;
		for (bw = 0; bw < 3; bw++)
		begin
			apb(1'b1, `OFS_LBW, 32'(bw));
			for (d = 0; d < 8; d++)
			begin
				e = (d == 0 || d > 5) ? 3 : d;
				e = (bw == 0 && e > 3) ? 3 : e;
				e = (bw == 1 && e > 4) ? 4 : e;
				apb(1'b1, `OFS_LC2, 32'h50 | 32'(d));
				repeat (2) @(posedge pclk);
				chk(32'(damping_code), 32'(e));
			end
			chk(32'(active_bw), 32'(bw));
		end
		apb(1'b1, `OFS_LBW, 32'h7);
		repeat (2) @(posedge pclk);
		chk(32'(active_bw), 32'h6);
		apb(1'b1, `OFS_LBW, 32'h2);
		apb(1'b1, `OFS_LC2, 32'h53);
		$display("test damping finished");
	endtask

	task automatic t_lol;
		apb(1'b1, `OFS_MC9, 32'h1);
		apb(1'b1, `OFS_MS2, 32'h101);
		apb(1'b1, `OFS_PL1, 32'h2002);
		repeat (4) @(posedge pclk);
		chk(32'(active_bw), 32'h2);
		run <= 1'b0;
		for (i = 0; i < 200 && lol !== 1'b1; i++)
			@(posedge pclk);
		chk({30'h0, lol, state_locked}, 32'h2);
		@(posedge pclk);
		chk(32'(irq), 32'h1);
		apb(1'b0, `OFS_MS2, 32'h0);
		chk(rd, 32'h101);
		chk(32'(active_bw), 32'h6);
		run <= 1'b1;
		for (i = 0; i < 200 && lol !== 1'b0; i++)
			@(posedge pclk);
		for (i = 0; i < 200 && state_locked !== 1'b1; i++)
			@(posedge pclk);
		chk(32'(i >= LH - 3 && i <= LH + 3), 32'h1);
		apb(1'b1, `OFS_MS2, 32'h101);
		apb(1'b0, `OFS_MS2, 32'h0);
		chk(rd, 32'h100);
		chk({30'h0, irq, active_bw == 3'h2}, 32'h1);
		apb(1'b1, `OFS_PL1, 32'h2000);
		apb(1'b1, `OFS_MC9, 32'h0);
		$display("test loss of lock finished");
	endtask

	task automatic t_limits;
		apb(1'b1, `OFS_FL1, 32'h100);
		apb(1'b1, `OFS_FL2, 32'h0);
		apb(1'b1, `OFS_FL3, 32'hFFFF01);
		integral_freq <= 24'h000100;
		for (i = 0; i < 20 && lol !== 1'b1; i++)
			@(posedge pclk);
		chk(32'(lol), 32'h1);
		integral_freq <= 24'h0000FF;
		repeat (3) @(posedge pclk);
		chk(32'(lol), 32'h0);
		apb(1'b1, `OFS_FL3, 32'h000100);
		integral_freq <= 24'h000200;
		repeat (3) @(posedge pclk);
		apb(1'b0, `OFS_OPST, 32'h0);
		chk({30'h0, rd[1], lol}, 32'h2);
		integral_freq <= 24'h0;
		apb(1'b1, `OFS_FL3, 32'hFFFF00);
		for (i = 0; i < 200 && state_locked !== 1'b1; i++)
			@(posedge pclk);
		$display("test limits finished");
	endtask

	task automatic t_readout;
		integral_freq <= 24'h123456;
		apb(1'b0, `OFS_FR1, 32'h0);
		chk(rd, 32'h56);
		integral_freq <= 24'h0;
		apb(1'b0, `OFS_FR2, 32'h0);
		chk(rd, 32'h34);
		apb(1'b0, `OFS_FR3, 32'h0);
		chk(rd, 32'h12);
		$display("test readout finished");
	endtask

	task automatic t_multicycle_detector;
		chk(32'(nearest_edge), 32'h1);
		apb(1'b1, `OFS_TC1, 32'h1);
		repeat (3) @(posedge pclk);
		chk(32'(nearest_edge), 32'h0);
		apb(1'b1, `OFS_TC1, 32'h0);
		apb(1'b1, `OFS_PL2, 32'h000A0003);
		repeat (3) @(posedge pclk);
		chk({29'h0, mc_active, mc_in_loop, nearest_edge}, 32'h6);
		apb(1'b1, `OFS_REFC, 32'h1);
		repeat (3) @(posedge pclk);
		chk(32'(mc_active), 32'h0);
		apb(1'b1, `OFS_REFC, 32'h0);
		apb(1'b1, `OFS_MC9, 32'h2);
		repeat (3) @(posedge pclk);
		chk(32'(mc_active), 32'h0);
		apb(1'b1, `OFS_MC9, 32'h0);
		apb(1'b1, `OFS_PL2, 32'h000A0000);
		repeat (3) @(posedge pclk);
		chk(32'(mc_active), 32'h0);
		apb(1'b1, `OFS_REFC, 32'h2);
		ref_sel <= 1'b1;
		for (i = 0; i < 10 && realign !== 1'b1; i++)
			@(posedge pclk);
		chk(32'(i < 10), 32'h1);
		$display("test multicycle finished");
	endtask

	// Fine detector trips on a three-cycle feedback lag, coarse one on ten slipped cycles
	task automatic t_detect;
		apb(1'b1, `OFS_PL1, 32'h0101);
		repeat (20) @(posedge pclk);
		chk(32'(lol), 32'h0);
		fb_lag <= 5'h18;
		for (i = 0; i < 40 && lol !== 1'b1; i++)
			@(posedge pclk);
		chk(32'(lol), 32'h1);
		fb_lag <= 5'h00;
		apb(1'b1, `OFS_PL1, 32'h2000);
		apb(1'b1, `OFS_PL2, 32'h000A0004);
		fb_stop <= 1'b1;
		for (i = 0; i < 200 && lol !== 1'b1; i++)
			@(posedge pclk);
		chk(32'(i >= 70 && i <= 90), 32'h1);
		fb_stop <= 1'b0;
		apb(1'b1, `OFS_PL2, 32'h000A0000);
		repeat (3) @(posedge pclk);
		chk(32'(lol), 32'h0);
		$display("test detectors finished");
	endtask

	// Main sequence
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ref_sel = 1'b0;
		integral_freq = 24'h0;
		run = 1'b1;
		fb_stop = 1'b0;
		fb_lag = 5'h00;
		n_errors = 0;
		check_count = 0;
		cyc = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_damping_select;
		t_lol;
		t_limits;
		t_readout;
		t_multicycle_detector;
		t_detect;
		test_done;
	end
endmodule // dpll_phase_detect_lock_monitor_test
